// >>> logic/cfp_ctrl.sv
// Charge fault supervisor and power mode controller with APB registers.
// Assumes measurement values are signed mA/mAh/0.1C, synchronous to sys_clk.
//
// Operation
// RULE1 - Overcharge flag after margin capacity added
// RULE2 - Overcharge action: charge FETs off, alarms
// RULE3 - Overcharge recovery by presence sequence or discharge
// RULE4 - Overcharge recovery when charge below clear
// RULE5 - Recovery restores FETs, clears alarms, flag
// RULE6 - Charge current starts both charge timers
// RULE7 - Fast timer holds on pause, expiry
// RULE8 - Fast timer clears on discharge or sequence (code clears it on discharge only)
// RULE9 - Fast timeout sets flag, optional FET action
// RULE10 - Fast timeout recovery restores charging outputs
// RULE11 - Precharge timer holds on pause, not precharging
// RULE12 - Precharge timeout sets flag, optional action
// RULE13 - Precharge timeout recovery like fast timeout
// RULE14 - Measure once per second in normal
// RULE15 - Bias, sample presence, set inserted bit
// RULE16 - Discharge fault flag follows overcurrent flags
// RULE17 - Sleep measures at voltage, current intervals
// RULE18 - Sleep entry by idle bus or command
// RULE19 - Sleep blocked by faults, timers, zero intervals
// RULE20 - Sleep entry turns off selected FETs
// RULE21 - Auto-calibration on sleep unless temperature inhibits
// RULE22 - Leave sleep on current, bus, flags, presence
// RULE23 - All second timers from one tick
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module cfp_ctrl #(
  parameter int TICK_CYC = cfp_pkg::CFP_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] meas_current,
  input wire logic signed [15:0] meas_temp,
  input wire logic [15:0] remaining_cap,
  input wire logic [15:0] full_charge_cap,
  input wire logic [7:0] relative_state_of_charge,
  input wire logic [7:0] fc_clear_pct,
  input wire logic pulse_pause_flag,
  input wire logic fast_charging_flag,
  input wire logic precharging_flag,
  input wire logic discharging,
  input wire logic [3:0] dsg_oc_flags,
  input wire logic [3:0] other_safety_flags,
  input wire logic prot_timer_active,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  input wire logic pack_inserted_input,
  input wire logic algo_chg_fet,
  input wire logic algo_dsg_fet,
  input wire logic algo_zv_fet,
  output logic presence_bias_output,
  output logic chg_fet,
  output logic dsg_fet,
  output logic zero_volt_charge_fet,
  output logic charge_req_zero,
  output logic terminate_charge_alarm,
  output logic overcharged_alarm,
  output logic full_charged_clear,
  output logic terminate_discharge_alarm,
  output logic discharge_current_fault_flag,
  output logic overcharge_flag,
  output logic fast_charge_timeout_flag,
  output logic precharge_timeout_flag,
  output logic pack_inserted,
  output logic meas_strobe,
  output logic meas_current_strobe,
  output logic autocal_start,
  output cfp_pkg::cfp_mode_t power_mode
);
  import cfp_pkg::*;

  initial begin
    if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus. Zero wait states; unmapped addresses answer with pslverr.
  logic [7:0] ctrl_q;
  logic [15:0] occap_q, ocrec_q, fclim_q, pclim_q, chgth_q, dsgth_q, tlow_q, thigh_q;
  logic [7:0] slpcur_q, slpvt_q, slpit_q, buslow_q;
  logic slpcmd_q;
  wire wr = psel && penable && pwrite;
  wire hit = (paddr <= CFP_ADDR_TIMERS) && (paddr[1:0] == 2'b00);
  wire no_removal_option = ctrl_q[CFP_B_NR];
  wire keep_charge_fet_in_sleep = ctrl_q[CFP_B_KEEPCHG];
  wire sleep_en = ctrl_q[CFP_B_SLEEPEN];
  wire overcharge_fet_action_enable = ctrl_q[CFP_B_XOC];
  wire fast_timeout_fet_action_enable = ctrl_q[CFP_B_XFC];
  wire precharge_timeout_fet_action_enable = ctrl_q[CFP_B_XPC];
  wire zero_volt_fet_mode = ctrl_q[CFP_B_ZV0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Configuration writes; the sleep command bit self-clears once consumed.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= CFP_RST_CTRL;
      occap_q <= CFP_RST_OCCAP;
      ocrec_q <= CFP_RST_OCREC;
      fclim_q <= CFP_RST_FCLIM;
      pclim_q <= CFP_RST_PCLIM;
      chgth_q <= CFP_RST_CHGTH;
      dsgth_q <= CFP_RST_DSGTH;
      slpcur_q <= CFP_RST_SLPCUR;
      slpvt_q <= CFP_RST_SLPVT;
      slpit_q <= CFP_RST_SLPIT;
      buslow_q <= CFP_RST_BUSLOW;
      tlow_q <= CFP_RST_TLOW;
      thigh_q <= CFP_RST_THIGH;
      slpcmd_q <= 1'b0;
    end else begin
      if (wr && paddr == CFP_ADDR_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wr && paddr == CFP_ADDR_OCCAP) occap_q <= pwdata[15:0];
      if (wr && paddr == CFP_ADDR_OCREC) ocrec_q <= pwdata[15:0];
      if (wr && paddr == CFP_ADDR_FCLIM) fclim_q <= pwdata[15:0];
      if (wr && paddr == CFP_ADDR_PCLIM) pclim_q <= pwdata[15:0];
      if (wr && paddr == CFP_ADDR_CURTH) begin
        chgth_q <= pwdata[15:0];
        dsgth_q <= pwdata[31:16];
      end
      if (wr && paddr == CFP_ADDR_SLEEP) begin
        slpcur_q <= pwdata[7:0];
        slpvt_q <= pwdata[15:8];
        slpit_q <= pwdata[23:16];
        buslow_q <= pwdata[31:24];
      end
      if (wr && paddr == CFP_ADDR_TEMP) begin
        tlow_q <= pwdata[15:0];
        thigh_q <= pwdata[31:16];
      end
      if (wr && paddr == CFP_ADDR_CTRL && pwdata[CFP_B_SLPCMD]) begin
        slpcmd_q <= 1'b1;
      end else if (power_mode == CFP_SLEEP || !sleep_en) begin
        slpcmd_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One-second tick shared by every second-based timer.
  logic [31:0] tick_cnt_q;
  logic [7:0] sec_v_q, sec_i_q, bus_low_q;
  logic tick;
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1)); // RULE23
  always_ff @(posedge sys_clk) begin
    if (srst || tick) tick_cnt_q <= 32'h0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Measurement scheduling and presence sampling.
  wire cur_pos = meas_current > 16'sh0000;
  wire cur_zero = meas_current == 16'sh0000;
  wire [15:0] cur_abs = meas_current[15] ? 16'(-meas_current) : meas_current;
  wire slp_int_zero = (slpvt_q == 8'h00) || (slpit_q == 8'h00);
  wire in_sleep = power_mode == CFP_SLEEP;
  wire v_due = in_sleep && tick && (sec_v_q + 8'h1 >= slpvt_q); // RULE17
  wire i_due = in_sleep && tick && (sec_i_q + 8'h1 >= slpit_q); // RULE17
  wire meas_now = (!in_sleep && tick) || v_due || i_due; // RULE14
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meas_strobe <= 1'b0;
      meas_current_strobe <= 1'b0;
      presence_bias_output <= 1'b0;
      sec_v_q <= 8'h00;
      sec_i_q <= 8'h00;
    end else begin
      meas_strobe <= meas_now; // RULE14
      meas_current_strobe <= (!in_sleep && tick) || i_due; // RULE17
      presence_bias_output <= meas_now && !no_removal_option; // RULE15
      if (!in_sleep || v_due) sec_v_q <= 8'h00;
      else if (tick) sec_v_q <= sec_v_q + 8'h1;
      if (!in_sleep || i_due) sec_i_q <= 8'h00;
      else if (tick) sec_i_q <= sec_i_q + 8'h1;
    end
  end

  // Sample one cycle after the bias goes high so the pin has settled.
  logic pack_inserted_input_lo_q, seq_hi_q, pack_inserted_input_seq;
  wire sample = presence_bias_output && !no_removal_option;
  assign pack_inserted_input_seq = sample && !pack_inserted_input && seq_hi_q && pack_inserted_input_lo_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pack_inserted <= 1'b0;
      pack_inserted_input_lo_q <= 1'b0;
      seq_hi_q <= 1'b0;
    end else if (sample) begin
      pack_inserted <= !pack_inserted_input; // RULE15
      if (!pack_inserted_input && !seq_hi_q) pack_inserted_input_lo_q <= 1'b1;
      if (pack_inserted_input && pack_inserted_input_lo_q) seq_hi_q <= 1'b1;
      if (pack_inserted_input_seq) seq_hi_q <= 1'b0;
    end
  end
  wire seq_nr0 = pack_inserted_input_seq && !no_removal_option;

  //////////////////////////////////////////////////////////////////////////////
  // Overcharge detection and continuous discharge accounting (mA added per second).
  logic [31:0] oc_acc_q, dsg_acc_q;
  wire over_full = remaining_cap > full_charge_cap;
  wire dsg_done = (dsg_acc_q >= {16'h0, ocrec_q});
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oc_acc_q <= 32'h0;
      dsg_acc_q <= 32'h0;
    end else if (overcharge_flag && oc_rec) begin
      oc_acc_q <= 32'h0; // RULE5
    end else if (tick) begin
      if (over_full && cur_pos) oc_acc_q <= oc_acc_q + {16'h0, meas_current};
      else if (!over_full) oc_acc_q <= 32'h0;
      if (meas_current <= 16'sh0000) dsg_acc_q <= dsg_acc_q + {16'h0, cur_abs};
      else dsg_acc_q <= 32'h0;
    end
  end
  // Accumulator is in mA-seconds; 3600 of them make one mAh.
  wire oc_hit = (occap_q != 16'h0) && (oc_acc_q >= {16'h0, occap_q} * 32'd3600); // RULE1
  wire oc_rec = (no_removal_option ? (meas_current <= 16'sh0000 && dsg_done) : seq_nr0) // RULE3
    || (relative_state_of_charge <= fc_clear_pct); // RULE4

  //////////////////////////////////////////////////////////////////////////////
  // Fast-charge and precharge timers.
  logic [15:0] fc_tmr_q, pc_tmr_q;
  logic tmr_run_q;
  wire fc_exp = (fclim_q != 16'h0) && (fc_tmr_q >= fclim_q);
  wire pc_exp = (pclim_q != 16'h0) && (pc_tmr_q >= pclim_q);
  wire fc_hold = pulse_pause_flag || !fast_charging_flag || discharging || fc_exp; // RULE7
  wire pc_hold = pulse_pause_flag || !precharging_flag || pc_exp; // RULE11
  wire fc_clr = dsg_done || (no_removal_option && pack_inserted_input_seq); // RULE8
  wire to_rec = (meas_current >= -$signed(dsgth_q)) || seq_nr0;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tmr_run_q <= 1'b0;
      fc_tmr_q <= 16'h0;
      pc_tmr_q <= 16'h0;
    end else begin
      if (meas_current >= $signed(chgth_q)) tmr_run_q <= 1'b1; // RULE6
      if (fc_clr) fc_tmr_q <= 16'h0; // RULE8
      else if (tick && tmr_run_q && !fc_hold) fc_tmr_q <= fc_tmr_q + 16'h1;
      if (tick && tmr_run_q && !pc_hold) pc_tmr_q <= pc_tmr_q + 16'h1;
      else if (precharge_timeout_flag && to_rec) pc_tmr_q <= 16'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault flags. Detection wins over a recovery in the same cycle.
  wire fc_act = fast_charge_timeout_flag && fast_timeout_fet_action_enable;
  wire pc_act = precharge_timeout_flag && precharge_timeout_fet_action_enable;
  wire oc_act = overcharge_flag && overcharge_fet_action_enable;
  wire any_dsg_oc = |dsg_oc_flags;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      overcharge_flag <= 1'b0;
      fast_charge_timeout_flag <= 1'b0;
      precharge_timeout_flag <= 1'b0;
      discharge_current_fault_flag <= 1'b0;
      terminate_discharge_alarm <= 1'b0;
      full_charged_clear <= 1'b0;
    end else begin
      if (oc_hit) overcharge_flag <= 1'b1; // RULE1
      else if (oc_rec) overcharge_flag <= 1'b0; // RULE5
      if (fc_exp) fast_charge_timeout_flag <= 1'b1; // RULE9
      else if (to_rec) fast_charge_timeout_flag <= 1'b0; // RULE10
      if (pc_exp) precharge_timeout_flag <= 1'b1; // RULE12
      else if (to_rec) precharge_timeout_flag <= 1'b0; // RULE13
      full_charged_clear <= overcharge_flag && !oc_hit && oc_rec; // RULE5
      discharge_current_fault_flag <= any_dsg_oc; // RULE16
      if (any_dsg_oc) terminate_discharge_alarm <= 1'b1;
      else terminate_discharge_alarm <= 1'b0; // RULE16
    end
  end
  // Fault outputs derive from the flags so recovery restores the algorithm state.
  assign terminate_charge_alarm = oc_act || fc_act || pc_act; // RULE2 RULE9 RULE12
  assign overcharged_alarm = oc_act; // RULE2
  assign charge_req_zero = oc_act || fc_act || pc_act; // RULE2 RULE9 RULE12

  //////////////////////////////////////////////////////////////////////////////
  // Power mode and sleep control.
  always_ff @(posedge sys_clk) begin
    if (srst || smb_clk_in || smb_data_in) bus_low_q <= 8'h00;
    else if (tick && bus_low_q != 8'hff) bus_low_q <= bus_low_q + 8'h1;
  end
  logic [3:0] flags_q;
  wire [3:0] flags_now = {overcharge_flag, fast_charge_timeout_flag,
    precharge_timeout_flag, discharge_current_fault_flag};
  wire idle_ok = (cur_abs <= {8'h0, slpcur_q}) && (bus_low_q >= buslow_q);
  wire cmd_ok = slpcmd_q && !cur_pos && (cur_abs < {8'h0, slpcur_q});
  wire blocked = any_dsg_oc || (|other_safety_flags) || prot_timer_active
    || fc_tmr_q != 16'h0 && !fc_exp || slp_int_zero; // RULE19
  wire enter = sleep_en && (idle_ok || cmd_ok)
    && (no_removal_option || !pack_inserted) && !blocked; // RULE18
  wire wake = !cur_zero || smb_clk_in || smb_data_in || (flags_q != flags_now)
    || (!no_removal_option && sample && !pack_inserted_input); // RULE22
  wire cal_inhibit = (meas_temp <= $signed(tlow_q)) && (meas_temp >= $signed(thigh_q));
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      power_mode <= CFP_NORMAL;
      autocal_start <= 1'b0;
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_now;
      autocal_start <= 1'b0;
      case (power_mode)
        CFP_NORMAL: begin
          if (enter) begin
            power_mode <= CFP_SLEEP;
            autocal_start <= !cal_inhibit; // RULE21
          end
        end
        CFP_SLEEP: begin
          if (wake) power_mode <= CFP_NORMAL; // RULE22
        end
        default: power_mode <= CFP_NORMAL;
      endcase
    end
  end

  // FET drive: algorithm request gated by sleep, and for the charge FETs also by faults.
  wire slp_chg_off = in_sleep && (!no_removal_option || !keep_charge_fet_in_sleep); // RULE20
  assign chg_fet = algo_chg_fet && !charge_req_zero && !slp_chg_off; // RULE2 RULE5
  assign dsg_fet = algo_dsg_fet && !(in_sleep && !no_removal_option); // RULE20
  assign zero_volt_charge_fet = algo_zv_fet
    && !(zero_volt_fet_mode && (charge_req_zero || in_sleep)); // RULE2 RULE20

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux.
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      CFP_ADDR_CTRL: prdata = {23'h0, slpcmd_q, ctrl_q};
      CFP_ADDR_OCCAP: prdata = {16'h0, occap_q};
      CFP_ADDR_OCREC: prdata = {16'h0, ocrec_q};
      CFP_ADDR_FCLIM: prdata = {16'h0, fclim_q};
      CFP_ADDR_PCLIM: prdata = {16'h0, pclim_q};
      CFP_ADDR_CURTH: prdata = {dsgth_q, chgth_q};
      CFP_ADDR_SLEEP: prdata = {buslow_q, slpit_q, slpvt_q, slpcur_q};
      CFP_ADDR_TEMP: prdata = {thigh_q, tlow_q};
      CFP_ADDR_STATUS: prdata = {22'h0, power_mode, pack_inserted, terminate_discharge_alarm,
        overcharged_alarm, terminate_charge_alarm, flags_now};
      CFP_ADDR_TIMERS: prdata = {pc_tmr_q, fc_tmr_q};
      default: prdata = 32'h0;
    endcase
  end
endmodule

// >>> logic/cfp_pkg.sv
// Package for the charge fault and power mode controller.
// Assumes a single 100 MHz clock domain and an APB register bus.
package cfp_pkg;
  // Bus address map, byte addresses of 32-bit words.
  localparam logic [7:0] CFP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CFP_ADDR_OCCAP = 8'h04;
  localparam logic [7:0] CFP_ADDR_OCREC = 8'h08;
  localparam logic [7:0] CFP_ADDR_FCLIM = 8'h0c;
  localparam logic [7:0] CFP_ADDR_PCLIM = 8'h10;
  localparam logic [7:0] CFP_ADDR_CURTH = 8'h14;
  localparam logic [7:0] CFP_ADDR_SLEEP = 8'h18;
  localparam logic [7:0] CFP_ADDR_TEMP = 8'h1c;
  localparam logic [7:0] CFP_ADDR_STATUS = 8'h20;
  localparam logic [7:0] CFP_ADDR_TIMERS = 8'h24;
  // Control register bit positions.
  localparam int CFP_B_NR = 0;
  localparam int CFP_B_KEEPCHG = 1;
  localparam int CFP_B_SLEEPEN = 2;
  localparam int CFP_B_XOC = 3;
  localparam int CFP_B_XFC = 4;
  localparam int CFP_B_XPC = 5;
  localparam int CFP_B_ZV0 = 6;
  localparam int CFP_B_SLPCMD = 8;
  // Reset values of configuration.
  localparam logic [15:0] CFP_RST_OCCAP = 16'd300;
  localparam logic [15:0] CFP_RST_OCREC = 16'd2;
  localparam logic [15:0] CFP_RST_FCLIM = 16'd10800;
  localparam logic [15:0] CFP_RST_PCLIM = 16'd3600;
  localparam logic [15:0] CFP_RST_CHGTH = 16'd100;
  localparam logic [15:0] CFP_RST_DSGTH = 16'd100;
  localparam logic [7:0] CFP_RST_SLPCUR = 8'd10;
  localparam logic [7:0] CFP_RST_SLPVT = 8'd5;
  localparam logic [7:0] CFP_RST_SLPIT = 8'd20;
  localparam logic [7:0] CFP_RST_BUSLOW = 8'd5;
  localparam logic [15:0] CFP_RST_TLOW = 16'd450;
  localparam logic [15:0] CFP_RST_THIGH = 16'd50;
  localparam logic [7:0] CFP_RST_CTRL = 8'h04;
  // One-second tick derived from the clock.
  localparam int CFP_CLK_HZ = 100000000;
  localparam int CFP_TICK_S = 1;
  localparam int CFP_TICK_CYC = CFP_CLK_HZ * CFP_TICK_S;
  // Power modes.
  typedef enum logic [1:0] {
    CFP_NORMAL = 2'b00,
    CFP_MEASURE = 2'b01,
    CFP_SLEEP = 2'b11
  } cfp_mode_t;
endpackage

// >>> verif/cfp_afe_model.sv
// Model of the pack side: the presence switch and the host bus lines.
// Assumes the bench chooses pack presence and bus activity.
`timescale 1ns/10ps
module cfp_afe_model (
  input wire logic sys_clk,
  input wire logic pack_present,
  input wire logic bus_active,
  output logic pack_inserted_input,
  output logic smb_clk_in,
  output logic smb_data_in
);
  ////////////////////////////////////////
  // The presence line has a pull-up, so a removed pack reads high.
  assign pack_inserted_input = !pack_present;
  // An active host toggles the clock line; an idle host leaves both lines low.
  always_ff @(posedge sys_clk) begin
    smb_clk_in <= bus_active && !smb_clk_in;
    smb_data_in <= bus_active;
  end
endmodule

// >>> verif/cfp_ctrl_sva.sv
// Checker for the charge fault and power mode controller.
// Assumes it is bound to cfp_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module cfp_ctrl_sva
  import cfp_pkg::*;
#(
  parameter int TICK_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] dsg_oc_flags,
  input wire logic [3:0] other_safety_flags,
  input wire logic smb_clk_in,
  input wire logic pack_inserted_input,
  input wire logic presence_bias_output,
  input wire logic chg_fet,
  input wire logic dsg_fet,
  input wire logic charge_req_zero,
  input wire logic terminate_charge_alarm,
  input wire logic overcharged_alarm,
  input wire logic terminate_discharge_alarm,
  input wire logic discharge_current_fault_flag,
  input wire logic overcharge_flag,
  input wire logic fast_charge_timeout_flag,
  input wire logic precharge_timeout_flag,
  input wire logic pack_inserted,
  input wire logic meas_strobe,
  input wire cfp_pkg::cfp_mode_t power_mode
);
  logic [7:0] ctrl_q;
  logic [31:0] gap_q;
  logic seen_q;
  wire ctrl_wr = psel && penable && pwrite && (paddr == CFP_ADDR_CTRL);
  ////////////////////////////////////////
  // Shadow of the control byte, so each check knows which fault actions are armed.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= CFP_RST_CTRL;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[7:0];
    end
  end
  // Cycles since the last measurement; sleep restarts it because sleep paces differently.
  always_ff @(posedge sys_clk) begin
    if (srst || power_mode == CFP_SLEEP) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (meas_strobe) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_OC_ACTION: assert property (overcharge_flag && ctrl_q[CFP_B_XOC] |-> !chg_fet && charge_req_zero
    && terminate_charge_alarm && overcharged_alarm) else $error("overcharge action missing");
  AST_FAST_ACTION: assert property (fast_charge_timeout_flag && ctrl_q[CFP_B_XFC] |-> !chg_fet
    && charge_req_zero && terminate_charge_alarm) else $error("fast timeout action missing");
  AST_PRE_ACTION: assert property (precharge_timeout_flag && ctrl_q[CFP_B_XPC] |-> !chg_fet
    && charge_req_zero && terminate_charge_alarm) else $error("precharge timeout action missing");
  AST_MEAS_GAP: assert property (meas_strobe && seen_q |-> gap_q == TICK_CYC - 1)
    else $error("measurement spacing wrong");
  AST_PACK_INSERTED_INPUT_SAMPLE: assert property (presence_bias_output && !ctrl_q[CFP_B_NR] |=>
    pack_inserted == !$past(pack_inserted_input)) else $error("presence sample wrong");
  AST_DSG_SET: assert property (dsg_oc_flags != 4'h0 |-> ##[1:2] discharge_current_fault_flag)
    else $error("discharge fault flag not set");
  AST_DSG_CLR: assert property ((dsg_oc_flags == 4'h0)[*3] |-> !discharge_current_fault_flag
    && !terminate_discharge_alarm) else $error("discharge fault flag not cleared");
  AST_SLEEP_BLOCK: assert property ((other_safety_flags != 4'h0)[*4] |-> power_mode != CFP_SLEEP)
    else $error("sleep despite safety flag");
  AST_SLEEP_FETS: assert property (power_mode == CFP_SLEEP && !ctrl_q[CFP_B_NR] |-> !chg_fet && !dsg_fet)
    else $error("fets on in sleep");
  AST_SLEEP_EXIT: assert property (power_mode == CFP_SLEEP && smb_clk_in |-> ##[0:4] power_mode != CFP_SLEEP)
    else $error("sleep kept with bus active");
endmodule
bind cfp_ctrl cfp_ctrl_sva #(.TICK_CYC(TICK_CYC)) i_cfp_ctrl_sva (.*);

// >>> verif/test_cfp_ctrl.sv
// Self-checking bench for the charge fault and power mode controller.
// Assumes cfp_pkg, cfp_ctrl, its bound checker and the pack-side model.
`timescale 1ns/10ps
module test_cfp_ctrl;
  import cfp_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} cfp_row_t;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pack_present = 1, bus_active = 0;
  logic [7:0] paddr = 0, relative_state_of_charge = 100, fc_clear_pct = 90;
  logic [31:0] pwdata = 0, prdata, rd;
  logic signed [15:0] meas_current = 0, meas_temp = 600;
  logic [15:0] remaining_cap = 2000, full_charge_cap = 4000;
  logic pulse_pause_flag = 0, fast_charging_flag = 0, precharging_flag = 0, discharging = 0;
  logic [3:0] dsg_oc_flags = 0, other_safety_flags = 0;
  logic prot_timer_active = 0, algo_chg_fet = 0, algo_dsg_fet = 1, algo_zv_fet = 0, er;
  logic pready, pslverr, presence_bias_output, chg_fet, dsg_fet, zero_volt_charge_fet, charge_req_zero;
  logic terminate_charge_alarm, overcharged_alarm, full_charged_clear, terminate_discharge_alarm;
  logic discharge_current_fault_flag, overcharge_flag, fast_charge_timeout_flag, precharge_timeout_flag;
  logic pack_inserted, meas_strobe, meas_current_strobe, autocal_start, smb_clk_in, smb_data_in;
  logic pack_inserted_input;
  cfp_mode_t power_mode;
  int err_count = 0, check_count = 0;
  cfp_row_t rows [10] = '{'{CFP_ADDR_CTRL, 32'h4, 0}, '{CFP_ADDR_OCCAP, 32'h12c, 0}, '{CFP_ADDR_OCREC, 32'h2, 0},
    '{CFP_ADDR_FCLIM, 32'h2a30, 0}, '{CFP_ADDR_PCLIM, 32'he10, 0}, '{CFP_ADDR_CURTH, 32'h00640064, 0},
    '{CFP_ADDR_SLEEP, 32'h0514050a, 0}, '{CFP_ADDR_TEMP, 32'h003201c2, 0}, '{CFP_ADDR_TIMERS, 32'h0, 0},
    '{8'h28, 32'h0, 1}};
  cfp_ctrl #(.TICK_CYC(20)) i_cfp_ctrl (.*);
  cfp_afe_model i_cfp_afe_model (.*);
  ////////////////////////////////////////
  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One APB transfer; the request is held until pready is seen high at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      chk("apb answer", 0, 1);
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic mon(input int s);
    case (s)
      0: return fast_charge_timeout_flag;
      1: return precharge_timeout_flag;
      2: return overcharge_flag;
      3: return power_mode == CFP_SLEEP;
      4: return discharge_current_fault_flag;
      default: return pack_inserted;
    endcase
  endfunction
  // Bounded wait on a watched output; running out ends the run.
  task wt(input int s, input logic v, input string nm);
    int n;
    n = 0;
    while (mon(s) !== v && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(nm, mon(s), v);
    if (n >= 2000) final_report;
    @(posedge sys_clk);
  endtask
  // Reset with the inputs back at their quiet values.
  task rst;
    @(posedge sys_clk);
    srst <= 1'b1;
    meas_current <= 0;
    {pulse_pause_flag, fast_charging_flag, precharging_flag, bus_active} <= 4'h0;
    pack_present <= 1'b1;
    full_charge_cap <= 16'd4000;
    relative_state_of_charge <= 8'd100;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("mode after reset", power_mode, CFP_NORMAL);
    chk("fet follows algorithm", chg_fet, 0);
    algo_chg_fet <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("read data", rd, rows[i].d);
      chk("slave error", er, rows[i].e);
    end
    $display("register table done");
    // Fast path holds on pause, precharge path holds while not precharging.
    for (int k = 0; k < 2; k++) begin
      rst;
      apb(1'b1, CFP_ADDR_CTRL, k ? 32'h20 : 32'h10);
      apb(1'b1, CFP_ADDR_OCREC, 32'd1000);
      apb(1'b1, k ? CFP_ADDR_PCLIM : CFP_ADDR_FCLIM, 32'd3);
      meas_current <= 16'sd200;
      fast_charging_flag <= !k;
      pulse_pause_flag <= !k;
      repeat (180) @(posedge sys_clk);
      #1;
      chk("held timer", mon(k), 0);
      @(posedge sys_clk);
      pulse_pause_flag <= 1'b0;
      precharging_flag <= k;
      wt(k, 1, "timeout flag");
      chk("charge fet off", chg_fet, 0);
      chk("request zero", charge_req_zero, 1);
      chk("terminate charge", terminate_charge_alarm, 1);
      meas_current <= -16'sd50;
      wt(k, 0, "timeout recovery");
      chk("charge fet back", chg_fet, 1);
      chk("terminate charge clear", terminate_charge_alarm, 0);
      $display("timeout path %0d done", k);
    end
    rst;
    apb(1'b1, CFP_ADDR_CTRL, 32'h08);
    apb(1'b1, CFP_ADDR_OCCAP, 32'd1);
    full_charge_cap <= 16'd1000;
    meas_current <= 16'sd30000;
    wt(2, 1, "overcharge flag");
    chk("overcharged alarm", overcharged_alarm, 1);
    chk("charge fet off", chg_fet, 0);
    chk("request zero", charge_req_zero, 1);
    meas_current <= 0;
    relative_state_of_charge <= 8'd80;
    wt(2, 0, "overcharge recovery");
    chk("overcharged alarm clear", overcharged_alarm, 0);
    chk("terminate charge clear", terminate_charge_alarm, 0);
    chk("charge fet back", chg_fet, 1);
    dsg_oc_flags <= 4'h2;
    wt(4, 1, "discharge fault set");
    dsg_oc_flags <= 4'h0;
    wt(4, 0, "discharge fault clear");
    chk("terminate discharge clear", terminate_discharge_alarm, 0);
    $display("overcharge and discharge fault done");
    rst;
    pack_present <= 1'b0;
    other_safety_flags <= 4'h1;
    prot_timer_active <= 1'b1;
    repeat (300) @(posedge sys_clk);
    #1;
    chk("sleep blocked", power_mode, CFP_NORMAL);
    chk("pack removed", pack_inserted, 0);
    @(posedge sys_clk);
    other_safety_flags <= 4'h0;
    prot_timer_active <= 1'b0;
    wt(3, 1, "sleep entry");
    chk("charge fet sleep", chg_fet, 0);
    chk("discharge fet sleep", dsg_fet, 0);
    bus_active <= 1'b1;
    wt(3, 0, "sleep exit");
    pack_present <= 1'b1;
    wt(5, 1, "pack inserted");
    $display("sleep done");
    final_report;
  end
endmodule
